// *** hdl/init_pkg.sv ***
package init_pkg;
    // Command encodings: {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_DESEL = 4'hf;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_LMR   = 4'h0;

    // Bank selects of the mode registers
    localparam logic [2:0] BANK_MR   = 3'h0;
    localparam logic [2:0] BANK_EMR1 = 3'h1;
    localparam logic [2:0] BANK_EMR2 = 3'h2;
    localparam logic [2:0] BANK_EMR3 = 3'h3;

    // Address bit positions
    localparam int ADDR_W      = 14;
    localparam int BIT_LOOP    = 8;
    localparam int BIT_ALLBANK = 10;
    localparam int BIT_EXT7    = 7;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_MRVAL  = 12'h008;
    localparam logic [11:0] OFF_EMRVAL = 12'h00c;

    // Control bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_SRATE = 1;

    // Timing in own units and cycle counts at 10 MHz
    localparam int CLK_NS      = 100;
    localparam int STABLE_US   = 200;
    localparam int CKE_WAIT_NS = 400;
    localparam int MRD_CYC     = 2;
    localparam int RFC_NS      = 200;
    localparam int LOCK_CYC    = 200;
    localparam int REF_COUNT   = 2;
    localparam int STABLE_CYC  = (STABLE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CKE_CYC     = (CKE_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RFC_CYC     = (RFC_NS + CLK_NS - 1) / CLK_NS;

    // Pin bundle toward the memory
    typedef struct packed {
        logic              cke;
        logic              termination_ctl;
        logic [3:0]        cmd;
        logic [2:0]        bank;
        logic [ADDR_W-1:0] addr;
    } mem_pins_s;
endpackage

// *** hdl/sdram_power_up_init.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Memory strobes reads edge-aligned; controller centers write strobes.
// - Write data captured on both strobe edges; reads on both edges.
// - Open a row with ACTIVE before READ or WRITE.
// - Hold termination control and clock gate low at power-up.
// - Only NOP for at least 200 us, then raise clock gate.
// - Wait at least 400 ns after clock gate, then precharge all.
// - Load extended register two; bit 7 self-refresh rate, rest zero.
// - Load extended register three with all bits zero.
// - Load extended register one, loop enabled, bits 7-9 zero.
// - Load main register with loop reset bit set.
// - Then precharge all and at least two refreshes.
// - Load main register with loop reset bit clear.
// - Load extended register one with bits 7-9 set.
// - Load extended register one with bits 7-9 cleared.
// - No normal access until 200 clocks after loop reset.
// - Precharge all drives address bit 10; banks decoded for loads.
// - Load mode only when idle; wait mode-register delay after.
module sdram_power_up_init
    import init_pkg::*;
#(
    parameter int STABLE_CYCLES = STABLE_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory pins
    output mem_pins_s        mem_pins
);
    // Wait counter holds 20 bits; longer waits cannot be served
    if (STABLE_CYCLES < 1 || STABLE_CYCLES > 2**20 - 1) begin : g_bad_stable
        $error("STABLE_CYCLES out of range");
    end

    // Initialisation steps, one-hot
    typedef enum logic [11:0] {
        ST_IDLE   = 12'h001,
        ST_STABLE = 12'h002,
        ST_CKE    = 12'h004,
        ST_PRE1   = 12'h008,
        ST_EMR2   = 12'h010,
        ST_EMR3   = 12'h020,
        ST_EMR1   = 12'h040,
        ST_MRRST  = 12'h080,
        ST_PRE2   = 12'h100,
        ST_REF    = 12'h200,
        ST_MRLOAD = 12'h400,
        ST_OCD    = 12'h800
    } step_e;

    // All sequencer and bus state in one record
    typedef struct packed {
        step_e       step;
        logic [19:0] wait_cnt;
        logic [7:0]  lock_cnt;
        logic [1:0]  ref_cnt;
        logic        ocd_phase;
        logic        lock_run;
        logic        done;
        logic        srate;
        logic [ADDR_W-1:0] mr_val;
        logic [ADDR_W-1:0] emr_val;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        mem_pins_s   pins;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // Issue one command with NOP filling the following wait
    function automatic mem_pins_s issue(input mem_pins_s p,
                                        input logic [3:0] c,
                                        input logic [2:0] b,
                                        input logic [ADDR_W-1:0] a);
        mem_pins_s r;
        r = p;
        r.cmd = c;
        r.bank = b;
        r.addr = a;
        return r;
    endfunction

    // Extended register one value with calibration field forced
    function automatic logic [ADDR_W-1:0] emr1(input logic [ADDR_W-1:0] v,
                                               input logic cal);
        logic [ADDR_W-1:0] r;
        r = v;
        r[BIT_EXT7 +: 3] = {3{cal}};
        // Bit 0 stays low so the loop stays enabled
        r[0] = 1'b0;
        return r;
    endfunction

    // Sequencer and register file
    always_comb begin
        logic [ADDR_W-1:0] a;
        logic              wr;
        logic              rd;
        // One wait state keeps read data registered
        wr = psel && penable && pwrite && !state_reg.pready;
        rd = psel && penable && !pwrite && !state_reg.pready;
        a = '0;
        state_next = state_reg;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.pins.cmd = CMD_NOP;
        state_next.pins.bank = '0;
        state_next.pins.addr = '0;
        if (psel && penable && !state_reg.pready) begin
            state_next.pready = 1'b1;
        end
        if (wr) begin
            unique case (paddr)
                OFF_CTRL: begin
                    state_next.srate = pwdata[CTRL_SRATE];
                    if (pwdata[CTRL_START] && state_reg.step == ST_IDLE
                        && !state_reg.done) begin
                        state_next.step = ST_STABLE;
                        state_next.wait_cnt = 20'(STABLE_CYCLES);
                    end
                end
                OFF_MRVAL:  state_next.mr_val = pwdata[ADDR_W-1:0];
                OFF_EMRVAL: state_next.emr_val = pwdata[ADDR_W-1:0];
                // Status is read-only, so a write is refused
                OFF_STATUS: state_next.pslverr = 1'b1;
                default:    state_next.pslverr = 1'b1;
            endcase
        end
        if (rd) begin
            // Unused bits read as zero
            state_next.prdata = '0;
            unique case (paddr)
                OFF_CTRL:   state_next.prdata[CTRL_SRATE] = state_reg.srate;
                OFF_STATUS: state_next.prdata = {19'h0, state_reg.step,
                                                 state_reg.done};
                OFF_MRVAL:  state_next.prdata[ADDR_W-1:0] = state_reg.mr_val;
                OFF_EMRVAL: state_next.prdata[ADDR_W-1:0] = state_reg.emr_val;
                default:    state_next.pslverr = 1'b1;
            endcase
        end
        // Runs beside the sequence, so the refreshes overlap it
        // loop lock count
        if (state_reg.lock_run) begin
            if (state_reg.lock_cnt == 8'h00) begin
                state_next.lock_run = 1'b0;
            end else begin
                state_next.lock_cnt = state_reg.lock_cnt - 8'h01;
            end
        end
        // One shared counter; each step loads the gap it needs
        // wait between commands
        if (state_reg.wait_cnt != 20'h00000) begin
            state_next.wait_cnt = state_reg.wait_cnt - 20'h00001;
        end else begin
            unique case (state_reg.step)
                ST_IDLE: begin
                    // Not started, or finished. No ACTIVE, READ or WRITE is
                    // ever issued here, so strobes and data lanes belong to
                    // the user logic once the done flag is up.
                end
                ST_STABLE: begin
                    // Start write loaded the 200 us NOP wait
                    // raise clock gate after stable time
                    state_next.pins.cke = 1'b1;
                    state_next.step = ST_CKE;
                    state_next.wait_cnt = 20'(CKE_CYC - 1);
                end
                ST_CKE: begin
                    // 400 ns have passed since the clock gate
                    state_next.step = ST_PRE1;
                end
                ST_PRE1: begin
                    a[BIT_ALLBANK] = 1'b1;
                    state_next.pins = issue(state_reg.pins, CMD_PRE, '0, a);
                    state_next.step = ST_EMR2;
                    state_next.wait_cnt = 20'(MRD_CYC - 1);
                end
                ST_EMR2: begin
                    a[BIT_EXT7] = state_reg.srate;
                    state_next.pins = issue(state_reg.pins, CMD_LMR,
                                            BANK_EMR2, a);
                    state_next.step = ST_EMR3;
                    state_next.wait_cnt = 20'(MRD_CYC - 1);
                end
                ST_EMR3: begin
                    state_next.pins = issue(state_reg.pins, CMD_LMR,
                                            BANK_EMR3, a);
                    state_next.step = ST_EMR1;
                    state_next.wait_cnt = 20'(MRD_CYC - 1);
                end
                ST_EMR1: begin
                    // Bit 0 low enables the loop
                    // loop enable, bits 7-9 zero
                    state_next.pins = issue(state_reg.pins, CMD_LMR,
                                            BANK_EMR1, a);
                    state_next.step = ST_MRRST;
                    state_next.wait_cnt = 20'(MRD_CYC - 1);
                end
                ST_MRRST: begin
                    a[BIT_LOOP] = 1'b1;
                    state_next.pins = issue(state_reg.pins, CMD_LMR,
                                            BANK_MR, a);
                    state_next.lock_run = 1'b1;
                    state_next.lock_cnt = 8'(LOCK_CYC - 1);
                    state_next.step = ST_PRE2;
                    state_next.wait_cnt = 20'(MRD_CYC - 1);
                end
                ST_PRE2: begin
                    a[BIT_ALLBANK] = 1'b1;
                    state_next.pins = issue(state_reg.pins, CMD_PRE, '0, a);
                    state_next.step = ST_REF;
                    state_next.ref_cnt = 2'(REF_COUNT);
                    state_next.wait_cnt = 20'(MRD_CYC - 1);
                end
                ST_REF: begin
                    state_next.pins = issue(state_reg.pins, CMD_REF, '0, a);
                    state_next.ref_cnt = state_reg.ref_cnt - 2'h1;
                    // Gap covers the refresh cycle time
                    state_next.wait_cnt = 20'(RFC_CYC - 1);
                    if (state_reg.ref_cnt == 2'h1) begin
                        state_next.step = ST_MRLOAD;
                    end
                end
                ST_MRLOAD: begin
                    a = state_reg.mr_val;
                    // Bit 8 forced low, else the loop would reset again
                    a[BIT_LOOP] = 1'b0;
                    state_next.pins = issue(state_reg.pins, CMD_LMR,
                                            BANK_MR, a);
                    state_next.step = ST_OCD;
                    state_next.ocd_phase = 1'b0;
                    state_next.wait_cnt = 20'(MRD_CYC - 1);
                end
                ST_OCD: begin
                    if (!state_reg.ocd_phase) begin
                        state_next.pins = issue(state_reg.pins, CMD_LMR,
                                BANK_EMR1, emr1(state_reg.emr_val, 1'b1));
                        state_next.ocd_phase = 1'b1;
                        state_next.wait_cnt = 20'(MRD_CYC - 1);
                    end else if (!state_reg.lock_run) begin
                        // Held here until the lock count has run out
                        // calibration exit, then ready
                        state_next.pins = issue(state_reg.pins, CMD_LMR,
                                BANK_EMR1, emr1(state_reg.emr_val, 1'b0));
                        state_next.step = ST_IDLE;
                        // Done stays set until reset; later starts ignored
                        // user access only once done
                        state_next.done = 1'b1;
                    end
                end
                default: begin
                    state_next.step = ST_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Mode values clear too and must be written again
            // clock gate and termination low
            state_reg <= '{step: ST_IDLE, pins: '{cmd: CMD_NOP,
                           default: '0}, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign mem_pins = state_reg.pins;
endmodule // sdram_power_up_init

// *** sim/sdram_init_chk_asserts.sv ***
`timescale 1ns/1ps
module sdram_init_chk
    import init_pkg::*;
#(
    parameter int STABLE_CYCLES = 10
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Memory pins
    input wire mem_pins_s   mem_pins
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] idle_reg;
    logic [15:0] idle_next;
    logic [8:0]  lock_reg;
    logic [8:0]  lock_next;
    // Counts idle clocks from the start write until the clock gate rises
    always_comb begin
        idle_next = idle_reg;
        if (!mem_pins.cke && idle_reg != 16'h0)
            idle_next = idle_reg + 16'h1;
        if (pready && pwrite && paddr == OFF_CTRL && pwdata[0])
            idle_next = 16'h1;
    end
    // Counts clocks since the loop-reset load, saturating at the top
    always_comb begin
        lock_next = lock_reg;
        if (lock_reg != 9'h000 && lock_reg != 9'h1ff)
            lock_next = lock_reg + 9'h001;
        if (mem_pins.cmd == CMD_LMR && mem_pins.bank == BANK_MR
            && mem_pins.addr[BIT_LOOP])
            lock_next = 9'h001;
    end
    // Helper counter registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_reg <= 16'h0;
            lock_reg <= 9'h000;
        end else begin
            idle_reg <= idle_next;
            lock_reg <= lock_next;
        end
    end
    a_term_low: assert property (!mem_pins.termination_ctl)
        else $error("termination control driven high");
    a_nop_gated: assert property (!mem_pins.cke |->
        mem_pins.cmd == CMD_NOP) else $error("command while clock gate low");
    a_stable_wait: assert property ($rose(mem_pins.cke) |->
        idle_reg > 16'(STABLE_CYCLES)) else $error("clock gate early");
    a_gate_holds: assert property (mem_pins.cke |=> mem_pins.cke)
        else $error("clock gate dropped");
    a_gate_wait: assert property ($rose(mem_pins.cke) |->
        (mem_pins.cmd == CMD_NOP) [*4]) else $error("precharge too soon");
    a_pre_all: assert property (mem_pins.cmd == CMD_PRE |->
        mem_pins.addr[BIT_ALLBANK]) else $error("precharge not all");
    a_load_gap: assert property (mem_pins.cmd == CMD_LMR |=>
        mem_pins.cmd == CMD_NOP) else $error("mode load gap short");
    a_cmd_pulse: assert property (mem_pins.cmd != CMD_NOP |=>
        mem_pins.cmd == CMD_NOP) else $error("commands not separated");
    a_lock_wait: assert property (mem_pins.cmd == CMD_LMR &&
        mem_pins.bank == BANK_EMR1 && mem_pins.addr[9:7] == 3'h0 &&
        lock_reg != 9'h000 |-> lock_reg >= 9'(LOCK_CYC))
        else $error("calibration exit before loop lock");
    a_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    c_gate: cover property ($rose(mem_pins.cke));
    c_refresh: cover property (mem_pins.cmd == CMD_REF);
    c_error: cover property (pready && pslverr);
endmodule // sdram_init_chk

bind sdram_power_up_init sdram_init_chk #(.STABLE_CYCLES(STABLE_CYCLES)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_pins(mem_pins));

// *** sim/sdram_model.sv ***
`timescale 1ns/1ps
module sdram_model
    import init_pkg::*;
(
    // Clock and reset
    input wire logic      pclk,
    input wire logic      presetn,
    // Command pins
    input wire mem_pins_s mem_pins,
    // Lock status
    output logic          ready
);
    // burst length and recovery fields land in mode_reg[0]
    // no data lanes here: the init run moves no data
    logic [ADDR_W-1:0] mode_reg [4];
    int                lock_cnt;
    // commands taken on rising edge, bank decoded
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt <= 0;
            ready <= 1'b0;
        end else begin
            // ready 200 clocks after loop reset
            if (lock_cnt > 0)
                lock_cnt <= lock_cnt + 1;
            ready <= lock_cnt > LOCK_CYC;
            if (lock_cnt == 2)
                mode_reg[0][BIT_LOOP] <= 1'b0;
            if (mem_pins.cke && mem_pins.cmd == CMD_LMR) begin
                mode_reg[mem_pins.bank[1:0]] <= mem_pins.addr;
                if (mem_pins.bank == BANK_MR && mem_pins.addr[BIT_LOOP])
                    lock_cnt <= 1;
            end
        end
    end
endmodule // sdram_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
    import init_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    mem_pins_s   mem_pins;
    logic        ready;
    int          bad_count = 0;
    int          checks_done = 0;
    int          seed = 53;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [20:0] cexp_q[$];
    logic [20:0] cmsk_q[$];
    logic [13:0] mrv;
    logic [13:0] emv;
    logic        srate;
    logic [32:0] m_now;
    localparam logic [32:0] WM = 33'h1_0000_0000;
    localparam logic [20:0] LM = 21'h1f_ffff;

    sdram_power_up_init #(.STABLE_CYCLES(10)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_pins(mem_pins));
    sdram_model mem (.pclk(pclk), .presetn(presetn), .mem_pins(mem_pins),
        .ready(ready));

    // Free-running bus clock
    always #50 pclk = ~pclk;

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d errors=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One APB transfer; expectation queued for the monitor
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait states: pready is sampled at each rising edge
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle clock keeps psel from being set twice in a step
        @(posedge pclk);
    endtask

    task automatic pc(input logic [3:0] c, input logic [2:0] b,
                      input logic [13:0] a, input logic [20:0] m);
        cexp_q.push_back({c, b, a});
        cmsk_q.push_back(m);
    endtask

    // Monitor: settled outputs against the oldest queued note
    always @(negedge pclk) begin
        if (presetn && pready === 1'b1 && exp_q.size() != 0) begin
            m_now = msk_q.pop_front();
            chk({pslverr, prdata} & m_now, exp_q.pop_front() & m_now);
        end
        if (presetn && mem_pins.cmd !== CMD_NOP && cexp_q.size() == 0)
            chk(33'(mem_pins.cmd), 33'(CMD_NOP));
        else if (presetn && mem_pins.cmd !== CMD_NOP)
            chk(33'({mem_pins.cmd, mem_pins.bank, mem_pins.addr}
                & cmsk_q.pop_front()), 33'(cexp_q.pop_front()));
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        mrv = 14'($random(seed));
        emv = 14'($random(seed));
        srate = 1'($random(seed));
        apb(1'b0, OFF_STATUS, 32'h0, 33'h2, 33'h1_0000_1fff);
        apb(1'b0, 12'h010, 32'h0, WM, WM);
        apb(1'b1, OFF_STATUS, 32'h1, WM, WM);
        apb(1'b1, OFF_MRVAL, {18'h0, mrv}, 33'h0, WM);
        apb(1'b1, OFF_EMRVAL, {18'h0, emv}, 33'h0, WM);
        apb(1'b0, OFF_MRVAL, 32'h0, {19'h0, mrv}, 33'h1_0000_3fff);
        apb(1'b0, OFF_EMRVAL, 32'h0, {19'h0, emv}, 33'h1_0000_3fff);
        pc(CMD_PRE, 3'h0, 14'h0400, 21'h1e_0400);
        pc(CMD_LMR, BANK_EMR2, 14'(srate) << BIT_EXT7, LM);
        pc(CMD_LMR, BANK_EMR3, 14'h0, LM);
        pc(CMD_LMR, BANK_EMR1, 14'h0, LM);
        pc(CMD_LMR, BANK_MR, 14'h0100, LM);
        pc(CMD_PRE, 3'h0, 14'h0400, 21'h1e_0400);
        pc(CMD_REF, 3'h0, 14'h0, 21'h1e_0000);
        pc(CMD_REF, 3'h0, 14'h0, 21'h1e_0000);
        pc(CMD_LMR, BANK_MR, mrv & 14'h3eff, LM);
        pc(CMD_LMR, BANK_EMR1, (emv | 14'h0380) & 14'h3ffe, LM);
        pc(CMD_LMR, BANK_EMR1, emv & 14'h3c7e, LM);
        apb(1'b1, OFF_CTRL, {30'h0, srate, 1'b1}, 33'h0, WM);
        apb(1'b0, OFF_CTRL, 32'h0, {31'h0, srate, 1'b0}, 33'h1_0000_0002);
        for (int i = 0; i < 2000 && cexp_q.size() != 0; i++)
            @(posedge pclk);
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0, 33'h3, 33'h1_0000_1fff);
        chk(33'(ready), 33'h1);
        chk(33'(cexp_q.size()), 33'h0);
        // A second start once done must not replay the sequence
        apb(1'b1, OFF_CTRL, 32'h1, 33'h0, WM);
        repeat (40) @(posedge pclk);
        end_sim;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(5000 * 100);
        bad_count++;
        end_sim;
    end
endmodule // tb
